/* verilog/serial_loader_pkg.sv */
// Purpose: shared constants of the serial loader link front end
// Assumes: 32-bit APB data, one aligned word per register
// Notes: offsets and bit positions are used by the top and the bench
package serial_loader_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] RXD_OFS = 8'h08;
  localparam logic [7:0] TXD_OFS = 8'h0c;
  localparam logic [7:0] BAUD_OFS = 8'h10;

  // ==========================================================
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RELOCK_BIT = 1;
  localparam int CTRL_DROPZ_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h5;

  // ==========================================================
  // status fields
  localparam int ST_ASYNC_BIT = 0;
  localparam int ST_SYNC_BIT = 1;
  localparam int ST_RXV_BIT = 2;
  localparam int ST_TXP_BIT = 3;
  localparam int ST_BFAIL_BIT = 4;
  localparam int ST_OVR_BIT = 5;

  // ==========================================================
  // link constants
  localparam logic [7:0] ACK_BYTE = 8'hcc;
  localparam int DATA_BITS = 8;
  localparam int MIN_BIT_CLKS = 16;
  localparam logic [3:0] SYNC_FALLS = 4'ha;
  localparam logic [3:0] MEAS_FALLS = 4'h4;
  localparam logic [3:0] GAP_FALL = 4'h5;
  localparam int MEAS_SHIFT = 3;

  typedef enum {LINK_NONE, LINK_ASYNC, LINK_SYNC} link_e;

endpackage

/* verilog/async_byte_tx.sv */
// Purpose: byte transmitter of the asynchronous port
// Assumes: bit_clks stays stable while busy
// Notes: one start bit, eight data bits lsb first, one stop bit
`timescale 1ns/100ps
module async_byte_tx
  import serial_loader_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [CNT_W-1:0] bit_clks,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic txd
);

  logic [CNT_W-1:0] cnt;
  logic [3:0] bits;
  logic [8:0] sr;

  // ==========================================================
  // frame shifter, start bit goes out at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      txd <= 1'b1;
      cnt <= '0;
      bits <= 4'h0;
      sr <= 9'h1ff;
    end else if (ce) begin
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          txd <= 1'b0;
          cnt <= '0;
          bits <= 4'h0;
          sr <= {1'b1, data}; // 8 data, no parity, 1 stop
        end
      end else if (cnt == bit_clks - 1'b1) begin
        cnt <= '0;
        if (bits == 4'(DATA_BITS + 1)) begin
          busy <= 1'b0;
        end else begin
          txd <= sr[0];
          sr <= {1'b1, sr[8:1]};
          bits <= bits + 4'h1;
        end
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

/* verilog/sync_serial_slave.sv */
// Purpose: slave end of the synchronous serial port, link clock side
// Assumes: host is master, clock idles high, sample on rising edge
// Notes: clock may stop between frames; frame select resets the counter
`timescale 1ns/100ps
module sync_serial_slave (
  input wire logic presetn,
  input wire logic sync_clk,
  input wire logic sync_cs_n,
  input wire logic sync_mosi,
  output logic sync_miso,
  output logic sync_miso_oe,
  output logic [7:0] rx_byte,
  output logic rx_toggle,
  input wire logic [7:0] tx_byte,
  input wire logic tx_req,
  output logic tx_ack
);

  logic frame_rst_n;
  logic [2:0] bit_cnt;
  logic [6:0] in_sr;
  logic [6:0] out_sr;
  logic req_meta;
  logic req_sync;

  // counter lives only while the frame is selected
  assign frame_rst_n = presetn & ~sync_cs_n;

  // ==========================================================
  // receive: polarity 1, phase 1 -> sample on the rising edge
  always_ff @(posedge sync_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 3'h0;
      in_sr <= 7'h00;
    end else begin
      in_sr <= {in_sr[5:0], sync_mosi};
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // whole byte, msb first, handed over by toggle
  always_ff @(posedge sync_clk or negedge presetn) begin
    if (!presetn) begin
      rx_byte <= 8'h00;
      rx_toggle <= 1'b0;
    end else if (bit_cnt == 3'h7) begin
      rx_byte <= {in_sr, sync_mosi};
      rx_toggle <= ~rx_toggle;
    end
  end

  // ==========================================================
  // transmit request crossing and acknowledge
  always_ff @(negedge sync_clk or negedge presetn) begin
    if (!presetn) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      tx_ack <= 1'b0;
    end else begin
      req_meta <= tx_req;
      req_sync <= req_meta;
      if (bit_cnt == 3'h0 && req_sync != tx_ack) begin
        tx_ack <= ~tx_ack;
      end
    end
  end

  // drive on the falling edge; zeros when nothing is pending
  always_ff @(negedge sync_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sync_miso <= 1'b0;
      sync_miso_oe <= 1'b0;
      out_sr <= 7'h00;
    end else begin
      sync_miso_oe <= 1'b1;
      if (bit_cnt == 3'h0) begin
        if (req_sync != tx_ack) begin
          sync_miso <= tx_byte[7];
          out_sr <= tx_byte[6:0];
        end else begin
          sync_miso <= 1'b0;
          out_sr <= 7'h00;
        end
      end else begin
        sync_miso <= out_sr[6];
        out_sr <= {out_sr[5:0], 1'b0};
      end
    end
  end

endmodule

/* verilog/serial_loader_link_front_end.sv */
// Purpose: link front end of a boot-time serial loader
// Assumes: pclk is the crystal clock, APB slave registers
// Notes: sync port logic runs on the host's serial clock
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module serial_loader_link_front_end
  import serial_loader_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic async_rxd,
  output logic async_txd,
  input wire logic sync_clk,
  input wire logic sync_cs_n,
  input wire logic sync_mosi,
  output logic sync_miso,
  output logic sync_miso_oe
);

  typedef enum {AB_WAIT, AB_MEASURE} ab_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_e;

  // register decode shared by read mux and error answer
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // interval near the reference within a quarter either way
  // upper bound one bit wider so a slow reference cannot wrap
  function automatic logic near(input logic [CNT_W-1:0] iv,
                                input logic [CNT_W-1:0] rf);
    return iv >= rf - (rf >> 2) &&
           {1'b0, iv} <= {1'b0, rf} + {1'b0, rf >> 2};
  endfunction

  link_e link;
  ab_e ab_state;
  rx_e rx_state;
  logic [2:0] ctrl;
  logic relock;
  logic wr_fire;
  logic rd_fire;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic rxd_meta;
  logic rxd_sync;
  logic rxd_last;
  logic rxd_fall;
  logic ab_active;
  logic [CNT_W-1:0] ab_cnt;
  logic [CNT_W-1:0] ab_first;
  logic [CNT_W+2:0] ab_sum;
  logic [3:0] ab_falls;
  logic ab_bad;
  logic ab_ok;
  logic ab_fail;
  logic [CNT_W-1:0] bit_clks;
  logic [CNT_W-1:0] rx_cnt;
  logic [2:0] rx_bits;
  logic [7:0] rx_shift;
  logic arx_evt;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ovr;
  logic seek_nz;
  logic rx_evt;
  logic [7:0] rx_in;
  logic tx_pend;
  logic [7:0] tx_byte;
  logic atx_start;
  logic atx_busy;
  logic [7:0] s_rx_byte;
  logic s_rx_tog;
  logic srx_meta;
  logic srx_sync;
  logic srx_last;
  logic srx_evt;
  logic [7:0] s_tx_byte;
  logic s_tx_req;
  logic s_tx_ack;
  logic sack_meta;
  logic sack_sync;
  logic s_busy;

  // ==========================================================
  // APB slave: one wait state, answer registered
  assign wr_fire = ce & psel & penable & pready & pwrite;
  assign rd_fire = ce & psel & penable & pready & ~pwrite;
  assign relock = wr_fire & hit(paddr, CTRL_OFS) & pwdata[CTRL_RELOCK_BIT];
  assign addr_ok = hit(paddr, CTRL_OFS) | hit(paddr, STAT_OFS) |
                   hit(paddr, RXD_OFS) | hit(paddr, TXD_OFS) |
                   hit(paddr, BAUD_OFS);

  // read mux; unmapped and write-only words read as zero
  always_comb begin
    rd_mux = 32'h0;
    if (hit(paddr, CTRL_OFS)) begin
      rd_mux[2:0] = ctrl & ~(3'h1 << CTRL_RELOCK_BIT);
    end
    if (hit(paddr, STAT_OFS)) begin
      rd_mux[ST_ASYNC_BIT] = link == LINK_ASYNC;
      rd_mux[ST_SYNC_BIT] = link == LINK_SYNC;
      rd_mux[ST_RXV_BIT] = rx_valid;
      rd_mux[ST_TXP_BIT] = tx_pend | atx_busy | s_busy;
      rd_mux[ST_BFAIL_BIT] = ab_fail;
      rd_mux[ST_OVR_BIT] = rx_ovr;
    end
    if (hit(paddr, RXD_OFS)) begin
      rd_mux[7:0] = rx_data;
    end
    if (hit(paddr, BAUD_OFS)) begin
      rd_mux[CNT_W-1:0] = bit_clks;
    end
  end

  // pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (psel && penable && !pready) begin
        prdata <= rd_mux;
      end
    end
  end

  // control word; relock is a write-one pulse, never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_fire && hit(paddr, CTRL_OFS)) begin
      ctrl <= pwdata[2:0] & ~(3'h1 << CTRL_RELOCK_BIT);
    end
  end

  // ==========================================================
  // async line input: two flops before any logic reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_last <= 1'b1;
    end else if (ce) begin
      rxd_meta <= async_rxd;
      rxd_sync <= rxd_meta;
      rxd_last <= rxd_sync;
    end
  end

  assign rxd_fall = rxd_last & ~rxd_sync;

  // ==========================================================
  // port lock: first established wins, set beats relock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link <= LINK_NONE;
    end else if (ce) begin
      if (link == LINK_NONE && ab_ok) begin
        link <= LINK_ASYNC;
      end else if (link == LINK_NONE && srx_evt && ctrl[CTRL_EN_BIT]) begin
        link <= LINK_SYNC; // no rate detection on this port
      end else if (relock) begin
        link <= LINK_NONE;
      end
    end
  end

  // ==========================================================
  // baud detection: falls of 0x55 0x55 are 2 bits apart
  // all counts are crystal clocks, so the divisor follows it
  assign ab_active = link == LINK_NONE && ctrl[CTRL_EN_BIT];

  // the inter-byte gap may stretch if the host idles between bytes
  always_comb begin
    ab_bad = 1'b0;
    if (ab_falls == 4'h1) begin
      ab_bad = ab_cnt < CNT_W'(2 * MIN_BIT_CLKS);
    end else if (ab_falls == GAP_FALL) begin
      ab_bad = ab_cnt < ab_first - (ab_first >> 2);
    end else begin
      ab_bad = !near(ab_cnt, ab_first);
    end
  end

  // interval timer and checks; failure stays silent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_state <= AB_WAIT;
      ab_cnt <= '0;
      ab_first <= '0;
      ab_sum <= '0;
      ab_falls <= 4'h0;
      ab_ok <= 1'b0;
      bit_clks <= CNT_W'(MIN_BIT_CLKS);
    end else if (ce) begin
      ab_ok <= 1'b0;
      case (ab_state)
        AB_WAIT: begin
          if (ab_active && rxd_fall) begin
            ab_state <= AB_MEASURE;
            ab_cnt <= CNT_W'(1);
            ab_falls <= 4'h1;
            ab_sum <= '0;
          end
        end
        AB_MEASURE: begin
          if (!ab_active) begin
            ab_state <= AB_WAIT;
          end else if (rxd_fall) begin
            ab_cnt <= CNT_W'(1);
            ab_falls <= ab_falls + 4'h1;
            if (ab_falls == 4'h1) begin
              ab_first <= ab_cnt;
            end
            if (ab_falls <= MEAS_FALLS) begin
              ab_sum <= ab_sum + (CNT_W+3)'(ab_cnt);
            end
            if (ab_bad) begin
              ab_state <= AB_WAIT;
            end else if (ab_falls == SYNC_FALLS - 4'h1) begin
              // eight bit times measured, divide by eight
              bit_clks <= ab_sum[CNT_W+2:MEAS_SHIFT];
              ab_ok <= 1'b1;
              ab_state <= AB_WAIT;
            end
          end else if (&ab_cnt || (ab_falls > 4'h1 &&
                       {2'b00, ab_cnt} > {ab_first, 2'b00})) begin
            ab_state <= AB_WAIT; // stalled pattern
          end else begin
            ab_cnt <= ab_cnt + 1'b1;
          end
        end
        default: begin
          ab_state <= AB_WAIT;
        end
      endcase
    end
  end

  // failure flag, hardware set beats the relock clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_fail <= 1'b0;
    end else if (ce) begin
      if (ab_state == AB_MEASURE && ab_active &&
          ((rxd_fall && ab_bad) || &ab_cnt)) begin
        ab_fail <= 1'b1;
      end else if (relock || ab_ok) begin
        ab_fail <= 1'b0;
      end
    end
  end

  // ==========================================================
  // async receiver at the detected rate, mid-bit sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_bits <= 3'h0;
      rx_shift <= 8'h00;
      arx_evt <= 1'b0;
    end else if (ce) begin
      arx_evt <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (link == LINK_ASYNC && rxd_fall) begin
            rx_cnt <= '0;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt == (bit_clks >> 1)) begin
            rx_cnt <= '0;
            rx_bits <= 3'h0;
            rx_state <= rxd_sync ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt <= rx_cnt + 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_cnt == bit_clks - 1'b1) begin
            rx_cnt <= '0;
            rx_shift <= {rxd_sync, rx_shift[7:1]};
            rx_bits <= rx_bits + 3'h1;
            if (rx_bits == 3'(DATA_BITS - 1)) begin
              rx_state <= RX_STOP;
            end
          end else begin
            rx_cnt <= rx_cnt + 1'b1;
          end
        end
        RX_STOP: begin
          if (rx_cnt == bit_clks - 1'b1) begin
            arx_evt <= rxd_sync; // framing error drops the byte
            rx_state <= RX_IDLE;
          end else begin
            rx_cnt <= rx_cnt + 1'b1;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // sync port crossings: byte toggle in, ack toggle back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srx_meta <= 1'b0;
      srx_sync <= 1'b0;
      srx_last <= 1'b0;
      sack_meta <= 1'b0;
      sack_sync <= 1'b0;
    end else if (ce) begin
      srx_meta <= s_rx_tog;
      srx_sync <= srx_meta;
      srx_last <= srx_sync;
      sack_meta <= s_tx_ack;
      sack_sync <= sack_meta;
    end
  end

  assign srx_evt = srx_sync ^ srx_last;
  assign s_busy = s_tx_req ^ sack_sync;

  // ==========================================================
  // common receive register for either port
  assign rx_in = link == LINK_ASYNC ? rx_shift : s_rx_byte;
  assign rx_evt = (arx_evt && link == LINK_ASYNC) ||
                  (srx_evt && ctrl[CTRL_EN_BIT] && link != LINK_ASYNC);

  // leading zeros skipped while seeking, when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_ovr <= 1'b0;
      seek_nz <= 1'b1;
    end else if (ce) begin
      if (atx_start || (tx_pend && link == LINK_SYNC && !s_busy)) begin
        seek_nz <= 1'b1;
      end else if (rx_evt && rx_in != 8'h00) begin
        seek_nz <= 1'b0;
      end
      if (rx_evt && !(ctrl[CTRL_DROPZ_BIT] && seek_nz &&
                      rx_in == 8'h00)) begin
        rx_data <= rx_in;
        rx_valid <= 1'b1;
        rx_ovr <= rx_valid | (rx_ovr & ~relock); // set beats clear
      end else if (rd_fire && hit(paddr, RXD_OFS)) begin
        rx_valid <= 1'b0;
      end else if (relock) begin
        rx_ovr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // transmit holding byte; ack byte queued on detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pend <= 1'b0;
      tx_byte <= 8'h00;
    end else if (ce) begin
      if (ab_ok) begin
        tx_pend <= 1'b1;
        tx_byte <= ACK_BYTE;
      end else if (wr_fire && hit(paddr, TXD_OFS) &&
                   link != LINK_NONE && !tx_pend) begin
        tx_pend <= 1'b1;
        tx_byte <= pwdata[7:0];
      end else if (atx_start ||
                   (tx_pend && link == LINK_SYNC && !s_busy)) begin
        tx_pend <= 1'b0;
      end
    end
  end

  // dispatch to whichever port is locked
  assign atx_start = tx_pend & (link == LINK_ASYNC) & ~atx_busy & ~ab_ok;

  // sync handoff; data held until the ack toggle returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_tx_byte <= 8'h00;
      s_tx_req <= 1'b0;
    end else if (ce) begin
      if (tx_pend && link == LINK_SYNC && !s_busy && !ab_ok) begin
        s_tx_byte <= tx_byte;
        s_tx_req <= ~s_tx_req;
      end
    end
  end

  // ==========================================================
  // port engines
  async_byte_tx #(
    .CNT_W(CNT_W)
  ) u_atx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bit_clks(bit_clks), // detected divisor
    .start(atx_start),
    .data(tx_byte),
    .busy(atx_busy),
    .txd(async_txd)
  );

  sync_serial_slave u_sync (
    .presetn(presetn),
    .sync_clk(sync_clk),
    .sync_cs_n(sync_cs_n),
    .sync_mosi(sync_mosi),
    .sync_miso(sync_miso),
    .sync_miso_oe(sync_miso_oe),
    .rx_byte(s_rx_byte),
    .rx_toggle(s_rx_tog),
    .tx_byte(s_tx_byte),
    .tx_req(s_tx_req),
    .tx_ack(s_tx_ack)
  );

endmodule

/* test/serial_loader_link_front_end_assertions.sv */
// Purpose: port checks of the loader front end
// Assumes: ce held high while checked
// Notes: bound to the top after the module
`timescale 1ns/100ps
module loader_port_checker
  import serial_loader_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic async_txd,
  input wire logic sync_clk,
  input wire logic sync_cs_n,
  input wire logic sync_miso,
  input wire logic sync_miso_oe
);
  // ==========================================
  // bus and link checks
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd_ok;
  logic mapped;
  // read answers and decoded offsets
  assign rd_ok = pready && !pwrite;
  assign mapped = paddr inside {CTRL_OFS, STAT_OFS, RXD_OFS, TXD_OFS,
    BAUD_OFS};
  property p_wait;
    psel && !penable && ce ##1 psel && penable && ce |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("late answer");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
  property p_err;
    pready |-> pslverr == !mapped;
  endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_one_port;
    rd_ok && paddr == STAT_OFS |-> !(prdata[0] && prdata[1]);
  endproperty
  a_one_port: assert property (p_one_port) else $error("two ports");
  property p_floor;
    rd_ok && paddr == BAUD_OFS |-> prdata >= MIN_BIT_CLKS;
  endproperty
  a_floor: assert property (p_floor) else $error("short bit");
  property p_start;
    $fell(async_txd) |-> (!async_txd)[*8] ##1 (!async_txd)[*8];
  endproperty
  a_start: assert property (p_start) else $error("short start");
  property p_idle;
    $rose(presetn) |-> async_txd && !sync_miso_oe && !pready;
  endproperty
  a_idle: assert property (p_idle) else $error("bad reset state");
  property p_hold;
    !sync_cs_n && sync_clk && $past(sync_clk) |-> $stable(sync_miso);
  endproperty
  a_hold: assert property (p_hold) else $error("miso moved");
  property p_oe;
    sync_cs_n && $past(sync_cs_n) |-> !sync_miso_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("oe outside frame");
  property p_zero;
    !sync_miso_oe |-> !sync_miso;
  endproperty
  a_zero: assert property (p_zero) else $error("idle miso");
endmodule

bind serial_loader_link_front_end loader_port_checker #(.CNT_W(CNT_W))
  port_chk (.*);

/* test/loader_host_model.sv */
// Purpose: download host on both serial ports
// Assumes: async bit times are whole pclk periods
// Notes: serial clock stands high between frames
`timescale 1ns/100ps
module loader_host_model (
  output logic async_rxd,
  input wire logic async_txd,
  output logic sync_clk,
  output logic sync_cs_n,
  output logic sync_mosi,
  input wire logic sync_miso
);
  // ==========================================
  // link clock and idle levels
  localparam int HALF = 44; // serial clock below pclk/12 with margin
  logic lclk = 1'h0;
  // free link clock, phase unrelated to pclk
  always #7.5 lclk = ~lclk;
  // lines idle until a task drives them
  initial begin
    async_rxd = 1'h1;
    sync_clk = 1'h1; // polarity 1 idle
    sync_cs_n = 1'h1;
    sync_mosi = 1'h0;
  end
  // one 8N1 character, n pclk per bit, n >= 16 to pass detection
  task automatic tx_async(input logic [7:0] b, input int n);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      async_rxd = f[i];
      #(n * 100);
    end
  endtask
  // read one character back, stop bit in b[8]
  task automatic rx_async(input int n, output logic [8:0] b);
    @(negedge async_txd);
    #(n * 50);
    for (int i = 0; i < 9; i++) begin
      #(n * 100);
      b[i] = async_txd;
    end
  endtask
  // master frame, phase 1, msb first, zero pads
  task automatic spi(input logic [7:0] d, output logic [7:0] r);
    sync_cs_n = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      repeat (HALF) @(posedge lclk);
      sync_clk = 1'h0;
      sync_mosi = d[i];
      repeat (HALF) @(posedge lclk);
      r[i] = sync_miso;
      sync_clk = 1'h1;
    end
    repeat (HALF) @(posedge lclk);
    sync_cs_n = 1'h1;
    sync_mosi = ~sync_mosi; // released line holds the inverse of the last bit sent
  endtask
endmodule

/* test/tb_top.sv */
// Purpose: self-checking bench of the loader front end
// Assumes: host model drives both serial ports
// Notes: ce tied high; registers reached over apb
`timescale 1ns/100ps
module tb_top;
  import serial_loader_pkg::*;
  // ==========================================
  // signals and instances
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, async_rxd, async_txd;
  wire logic sync_clk, sync_cs_n, sync_mosi, sync_miso, sync_miso_oe;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int tx_falls = 0;
  logic [8:0] b;
  logic [7:0] r8;
  logic [31:0] r;
  logic e;
  serial_loader_link_front_end dut (.pclk(pclk), .presetn(presetn),
    .ce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .async_rxd(async_rxd), .async_txd(async_txd),
    .sync_clk(sync_clk), .sync_cs_n(sync_cs_n), .sync_mosi(sync_mosi),
    .sync_miso(sync_miso), .sync_miso_oe(sync_miso_oe));
  loader_host_model host (.async_rxd(async_rxd), .async_txd(async_txd),
    .sync_clk(sync_clk), .sync_cs_n(sync_cs_n), .sync_mosi(sync_mosi),
    .sync_miso(sync_miso));
  // crystal clock, 100 ns
  always #50 pclk = ~pclk;
  // characters leaving the device
  always @(negedge async_txd) tx_falls++;
  // hang guard, well above the few thousand cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  // ==========================================
  // shared tasks
  task automatic complete_run;
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %0t got %h want %h", $time, g, x);
    end
  endtask
  // request held until the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    apb(1'h0, a, 32'h0, r, e);
    chk({e, r}, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, r, e);
  endtask
  task automatic sync2(input int n);
    @(negedge pclk);
    host.tx_async(8'h55, n);
    host.tx_async(8'h55, n);
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    rd(CTRL_OFS, {30'h0, CTRL_RESET});
    rd(STAT_OFS, 33'h0);
    rd(BAUD_OFS, 33'h10);
    rd(8'h14, {1'h1, 32'h0});
    wr(TXD_OFS, 32'h77);
    rd(STAT_OFS, 33'h0);
  endtask
  task automatic t_bad;
    sync2(8);
    repeat (320) @(posedge pclk); // host waits twice the pattern
    rd(STAT_OFS, 33'h10);
    chk(33'(tx_falls), 33'h0);
    wr(CTRL_OFS, 32'h7);
    rd(STAT_OFS, 33'h0);
  endtask
  task automatic t_async;
    fork
      sync2(32);
      host.rx_async(32, b);
    join
    chk(33'(b), {24'h0, 1'h1, ACK_BYTE});
    repeat (40) @(posedge pclk);
    rd(BAUD_OFS, 33'h20);
    rd(STAT_OFS, 33'h1);
    @(negedge pclk);
    host.tx_async(8'ha5, 32);
    repeat (40) @(posedge pclk);
    rd(STAT_OFS, 33'h5);
    rd(RXD_OFS, 33'ha5);
    fork
      wr(TXD_OFS, 32'h3c);
      host.rx_async(32, b);
    join
    chk(33'(b), 33'h13c);
    host.spi(8'h96, r8);
    repeat (10) @(posedge pclk);
    rd(STAT_OFS, 33'h1);
  endtask
  task automatic t_sync;
    int falls;
    wr(CTRL_OFS, 32'h7);
    host.spi(8'h5a, r8);
    chk(33'(r8), 33'h0);
    repeat (10) @(posedge pclk);
    rd(STAT_OFS, 33'h6);
    rd(RXD_OFS, 33'h5a);
    wr(TXD_OFS, 32'h81);
    host.spi(8'h00, r8);
    chk(33'(r8), 33'h0); // request crosses in this frame
    host.spi(8'h00, r8);
    chk(33'(r8), 33'h81);
    falls = tx_falls;
    sync2(32);
    repeat (40) @(posedge pclk);
    apb(1'h0, STAT_OFS, 32'h0, r, e);
    chk(33'(r[1:0]), 33'h2);
    chk(33'(tx_falls - falls), 33'h0);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_bad;
    t_async;
    t_sync;
    complete_run;
  end
endmodule
